// File: design/ucrd_pkg.sv
// Purpose: Constants shared by the control request decoder.
// Assumes: Setup fields arrive already unpacked from the device core.
// Notes: Request codes and types follow the standard setup packet layout.
package ucrd_pkg;
  // Request type values.
  localparam logic [7:0] RT_DEV_OUT = 8'h00;
  localparam logic [7:0] RT_IF_OUT = 8'h01;
  localparam logic [7:0] RT_EP_OUT = 8'h02;
  localparam logic [7:0] RT_VENDOR_OUT = 8'h40;
  localparam logic [7:0] RT_DEV_IN = 8'h80;
  localparam logic [7:0] RT_IF_IN = 8'h81;
  localparam logic [7:0] RT_EP_IN = 8'h82;
  // Request codes.
  localparam logic [7:0] RQ_GET_STATUS = 8'h00;
  localparam logic [7:0] RQ_CLR_FEATURE = 8'h01;
  localparam logic [7:0] RQ_SET_FEATURE = 8'h03;
  localparam logic [7:0] RQ_SET_ADDRESS = 8'h05;
  localparam logic [7:0] RQ_GET_DESC = 8'h06;
  localparam logic [7:0] RQ_GET_CONFIG = 8'h08;
  localparam logic [7:0] RQ_SET_CONFIG = 8'h09;
  localparam logic [7:0] RQ_GET_IFACE = 8'h0a;
  localparam logic [7:0] RQ_SET_IFACE = 8'h0b;
  localparam logic [7:0] RQ_REG_WRITE = 8'ha0;
  // Descriptor types carried in the high byte of the value field.
  localparam logic [7:0] DT_DEVICE = 8'h01;
  localparam logic [7:0] DT_CONFIG = 8'h02;
  localparam logic [7:0] DT_STRING = 8'h03;
  localparam logic [7:0] DT_IFACE = 8'h04;
  localparam logic [7:0] DT_ENDPOINT = 8'h05;
  localparam logic [7:0] DT_QUALIFIER = 8'h06;
  localparam logic [7:0] DT_OTHER_SPEED = 8'h07;
  // Feature selectors.
  localparam logic [15:0] FS_EP_HALT = 16'h0000;
  localparam logic [15:0] FS_REMOTE_WAKE = 16'h0001;
  localparam logic [15:0] FS_TEST_MODE = 16'h0002;
  // Endpoint index values accepted by endpoint status reads.
  localparam logic [15:0] EPI_BULK_IN = 16'h0081;
  localparam logic [15:0] EPI_BULK_OUT = 16'h0002;
  localparam logic [15:0] EPI_INTR = 16'h0083;
  localparam int EP_COUNT = 4;
  localparam logic [7:0] CONFIG_ONE = 8'h01;
  // Data stage lengths.
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_TWO = 16'h0002;
  localparam logic [15:0] LEN_REG = 16'h0004;
  // Register address space; the MAC block starts at this address.
  localparam logic [11:0] MAC_CSR_BASE = 12'h100;
  localparam logic [1:0] REG_LAST_BYTE = 2'h3;
endpackage

// File: design/ucrd_decoder.sv
// Purpose: Decodes control requests of the default endpoint and keeps device state.
// Assumes: Setup, data and status handshakes come from the device core on sys_clk_i.
// Notes: Descriptor bytes are served outside; this block only requests them.
`timescale 1ns/1ps

module ucrd_decoder (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Setup stage
  input wire logic setup_valid_i,
  input wire logic [7:0] req_type_i,
  input wire logic [7:0] req_code_i,
  input wire logic [15:0] req_value_i,
  input wire logic [15:0] req_index_i,
  input wire logic [15:0] req_length_i,
  // Status stage
  input wire logic status_done_i,
  // Data stage towards the host
  output logic [7:0] in_data_o,
  output logic in_valid_o,
  output logic in_last_o,
  input wire logic in_ready_i,
  // Data stage from the host
  input wire logic [7:0] out_data_i,
  input wire logic out_valid_i,
  // Handshake and descriptor fetch
  output logic stall_o,
  output logic desc_req_o,
  output logic [7:0] desc_type_o,
  output logic [7:0] desc_index_o,
  output logic [15:0] desc_length_o,
  // Device state
  input wire logic self_powered_i,
  input wire logic normal_state_i,
  output logic [6:0] dev_addr_o,
  output logic configured_o,
  output logic [7:0] config_value_o,
  output logic remote_wakeup_o,
  output logic test_mode_o,
  output logic [7:0] test_sel_o,
  output logic [3:0] ep_stall_o,
  // Register write port
  output logic csr_wr_o,
  output logic [11:0] csr_addr_o,
  output logic [31:0] csr_wdata_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_DATA_IN, ST_DATA_OUT, ST_STATUS} ucrd_state_t;

  // True when an endpoint-recipient request names endpoint 0 to 3, direction bit ignored.
  function automatic logic ep_valid(input logic [15:0] idx);
    ep_valid = (idx[15:8] == 8'h00) && (idx[6:2] == 5'h00);
  endfunction

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] selfp_sync_q;
  ucrd_state_t state_q, state_d;
  logic [15:0] tx_buf_q, tx_buf_d;
  logic [1:0] cnt_q, cnt_d;
  logic [7:0] in_data_d;
  logic in_valid_d, in_last_d;
  logic stall_d, desc_req_d;
  logic [7:0] desc_type_d, desc_index_d;
  logic [15:0] desc_length_d;
  logic [6:0] dev_addr_d, addr_new_q, addr_new_d;
  logic addr_pend_q, addr_pend_d;
  logic configured_d, remote_wakeup_d, test_mode_d;
  logic [7:0] config_value_d, test_sel_d;
  logic [3:0] ep_stall_d;
  logic csr_wr_d;
  logic [11:0] csr_addr_d;
  logic [31:0] csr_wdata_d;

  // Reset release and strap synchroniser.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      selfp_sync_q <= 2'h0;
    end else begin
      selfp_sync_q <= {selfp_sync_q[0], self_powered_i};
    end
  end

  always_comb begin
    state_d = state_q;
    tx_buf_d = tx_buf_q;
    cnt_d = cnt_q;
    in_data_d = in_data_o;
    in_valid_d = in_valid_o;
    in_last_d = in_last_o;
    stall_d = stall_o;
    desc_req_d = 1'b0;
    desc_type_d = desc_type_o;
    desc_index_d = desc_index_o;
    desc_length_d = desc_length_o;
    dev_addr_d = dev_addr_o;
    addr_new_d = addr_new_q;
    addr_pend_d = addr_pend_q;
    configured_d = configured_o;
    config_value_d = config_value_o;
    remote_wakeup_d = remote_wakeup_o;
    test_mode_d = test_mode_o;
    test_sel_d = test_sel_o;
    ep_stall_d = ep_stall_o;
    csr_wr_d = 1'b0;
    csr_addr_d = csr_addr_o;
    csr_wdata_d = csr_wdata_o;
    case (state_q)
      ST_DATA_IN: begin
        if (in_valid_o && in_ready_i) begin
          if (in_last_o) begin
            in_valid_d = 1'b0;
            state_d = ST_STATUS;
          end else begin
            cnt_d = cnt_q + 2'h1;
            in_data_d = tx_buf_q[15:8];
            in_last_d = 1'b1;
          end
        end
      end
      ST_DATA_OUT: begin
        if (out_valid_i) begin
          csr_wdata_d = {out_data_i, csr_wdata_o[31:8]};
          cnt_d = cnt_q + 2'h1;
          if (cnt_q == ucrd_pkg::REG_LAST_BYTE) begin
            csr_wr_d = 1'b1;
            state_d = ST_STATUS;
          end
        end
      end
      ST_STATUS: begin
        if (status_done_i) begin
          if (addr_pend_q) begin
            dev_addr_d = addr_new_q;
          end
          addr_pend_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (setup_valid_i) begin
      stall_d = 1'b0;
      in_valid_d = 1'b0;
      in_last_d = 1'b0;
      addr_pend_d = 1'b0;
      cnt_d = 2'h0;
      tx_buf_d = 16'h0000;
      state_d = ST_STATUS;
      case (req_code_i)
        ucrd_pkg::RQ_CLR_FEATURE, ucrd_pkg::RQ_SET_FEATURE: begin
          if (req_length_i != 16'h0000) begin
            stall_d = 1'b1;
          end else if (req_type_i == ucrd_pkg::RT_DEV_OUT &&
                       req_value_i == ucrd_pkg::FS_REMOTE_WAKE) begin
            remote_wakeup_d = (req_code_i == ucrd_pkg::RQ_SET_FEATURE);
          end else if (req_type_i == ucrd_pkg::RT_DEV_OUT &&
                       req_value_i == ucrd_pkg::FS_TEST_MODE &&
                       req_code_i == ucrd_pkg::RQ_SET_FEATURE) begin
            test_mode_d = 1'b1;
            test_sel_d = req_index_i[15:8];
          end else if (req_type_i == ucrd_pkg::RT_EP_OUT &&
                       req_value_i == ucrd_pkg::FS_EP_HALT && ep_valid(req_index_i)) begin
            ep_stall_d[req_index_i[1:0]] = (req_code_i == ucrd_pkg::RQ_SET_FEATURE);
          end else begin
            stall_d = 1'b1;
          end
        end
        ucrd_pkg::RQ_GET_CONFIG, ucrd_pkg::RQ_GET_IFACE: begin
          if ((req_code_i == ucrd_pkg::RQ_GET_CONFIG && req_type_i == ucrd_pkg::RT_DEV_IN) ||
              (req_code_i == ucrd_pkg::RQ_GET_IFACE && req_type_i == ucrd_pkg::RT_IF_IN &&
               req_index_i == 16'h0000)) begin
            tx_buf_d = (req_code_i == ucrd_pkg::RQ_GET_CONFIG) ?
                       {8'h00, config_value_o} : 16'h0000;
            in_data_d = (req_code_i == ucrd_pkg::RQ_GET_CONFIG) ? config_value_o : 8'h00;
            in_valid_d = (req_length_i != 16'h0000);
            in_last_d = 1'b1;
            state_d = (req_length_i != 16'h0000) ? ST_DATA_IN : ST_STATUS;
          end else begin
            stall_d = 1'b1;
          end
        end
        ucrd_pkg::RQ_GET_STATUS: begin
          if (req_type_i == ucrd_pkg::RT_DEV_IN && req_index_i == 16'h0000) begin
            tx_buf_d = {14'h0, remote_wakeup_o, selfp_sync_q[1]};
          end else if (req_type_i == ucrd_pkg::RT_EP_IN &&
                       (req_index_i == ucrd_pkg::EPI_BULK_IN ||
                        req_index_i == ucrd_pkg::EPI_BULK_OUT ||
                        req_index_i == ucrd_pkg::EPI_INTR)) begin
            tx_buf_d = {15'h0, ep_stall_o[req_index_i[1:0]]};
          end else begin
            stall_d = 1'b1;
          end
          if (!stall_d && req_length_i != 16'h0000) begin
            in_data_d = tx_buf_d[7:0];
            in_valid_d = 1'b1;
            in_last_d = (req_length_i == ucrd_pkg::LEN_ONE);
            state_d = ST_DATA_IN;
          end
        end
        ucrd_pkg::RQ_SET_ADDRESS: begin
          if (req_type_i == ucrd_pkg::RT_DEV_OUT && req_length_i == 16'h0000) begin
            addr_new_d = req_value_i[6:0];
            addr_pend_d = 1'b1;
          end else begin
            stall_d = 1'b1;
          end
        end
        ucrd_pkg::RQ_GET_DESC: begin
          if (req_type_i == ucrd_pkg::RT_DEV_IN &&
              (req_value_i[15:8] == ucrd_pkg::DT_DEVICE ||
               req_value_i[15:8] == ucrd_pkg::DT_CONFIG ||
               req_value_i[15:8] == ucrd_pkg::DT_STRING ||
               req_value_i[15:8] == ucrd_pkg::DT_QUALIFIER ||
               req_value_i[15:8] == ucrd_pkg::DT_OTHER_SPEED)) begin
            desc_req_d = 1'b1;
            desc_type_d = req_value_i[15:8];
            desc_index_d = req_value_i[7:0];
            desc_length_d = req_length_i;
          end else begin
            stall_d = 1'b1;
          end
        end
        ucrd_pkg::RQ_SET_CONFIG: begin
          if (req_type_i == ucrd_pkg::RT_DEV_OUT && req_length_i == 16'h0000 &&
              req_value_i[15:8] == 8'h00 &&
              (req_value_i[7:0] == ucrd_pkg::CONFIG_ONE || req_value_i[7:0] == 8'h00)) begin
            config_value_d = req_value_i[7:0];
            configured_d = (req_value_i[7:0] == ucrd_pkg::CONFIG_ONE);
          end else begin
            stall_d = 1'b1;
          end
        end
        ucrd_pkg::RQ_SET_IFACE: begin
          stall_d = !(req_type_i == ucrd_pkg::RT_IF_OUT && req_value_i == 16'h0000 &&
                      req_index_i == 16'h0000);
        end
        ucrd_pkg::RQ_REG_WRITE: begin
          if (req_type_i == ucrd_pkg::RT_VENDOR_OUT && req_value_i == 16'h0000 &&
              req_index_i[15:12] == 4'h0 && req_length_i == ucrd_pkg::LEN_REG &&
              !(normal_state_i && req_index_i[11:0] >= ucrd_pkg::MAC_CSR_BASE)) begin
            csr_addr_d = req_index_i[11:0];
            state_d = ST_DATA_OUT;
          end else begin
            stall_d = 1'b1;
          end
        end
        default: begin
          stall_d = 1'b1;
        end
      endcase
      if (stall_d) begin
        state_d = ST_IDLE;
        in_valid_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      tx_buf_q <= 16'h0000;
      cnt_q <= 2'h0;
      in_data_o <= 8'h00;
      in_valid_o <= 1'b0;
      in_last_o <= 1'b0;
      stall_o <= 1'b0;
      desc_req_o <= 1'b0;
      desc_type_o <= 8'h00;
      desc_index_o <= 8'h00;
      desc_length_o <= 16'h0000;
      dev_addr_o <= 7'h00;
      addr_new_q <= 7'h00;
      addr_pend_q <= 1'b0;
      configured_o <= 1'b0;
      config_value_o <= 8'h00;
      remote_wakeup_o <= 1'b0;
      test_mode_o <= 1'b0;
      test_sel_o <= 8'h00;
      ep_stall_o <= 4'h0;
      csr_wr_o <= 1'b0;
      csr_addr_o <= 12'h000;
      csr_wdata_o <= 32'h00000000;
    end else begin
      state_q <= state_d;
      tx_buf_q <= tx_buf_d;
      cnt_q <= cnt_d;
      in_data_o <= in_data_d;
      in_valid_o <= in_valid_d;
      in_last_o <= in_last_d;
      stall_o <= stall_d;
      desc_req_o <= desc_req_d;
      desc_type_o <= desc_type_d;
      desc_index_o <= desc_index_d;
      desc_length_o <= desc_length_d;
      dev_addr_o <= dev_addr_d;
      addr_new_q <= addr_new_d;
      addr_pend_q <= addr_pend_d;
      configured_o <= configured_d;
      config_value_o <= config_value_d;
      remote_wakeup_o <= remote_wakeup_d;
      test_mode_o <= test_mode_d;
      test_sel_o <= test_sel_d;
      ep_stall_o <= ep_stall_d;
      csr_wr_o <= csr_wr_d;
      csr_addr_o <= csr_addr_d;
      csr_wdata_o <= csr_wdata_d;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_get_cfg;
    setup_valid_i && req_code_i == ucrd_pkg::RQ_GET_CONFIG &&
      req_type_i == ucrd_pkg::RT_DEV_IN && req_length_i == ucrd_pkg::LEN_ONE;
  endsequence
  sequence s_bad_desc;
    setup_valid_i && req_code_i == ucrd_pkg::RQ_GET_DESC &&
      (req_value_i[15:8] == ucrd_pkg::DT_IFACE || req_value_i[15:8] == ucrd_pkg::DT_ENDPOINT);
  endsequence
  sequence s_reg_wr;
    setup_valid_i && req_code_i == ucrd_pkg::RQ_REG_WRITE &&
      req_type_i == ucrd_pkg::RT_VENDOR_OUT && req_value_i == 16'h0000 &&
      req_length_i == ucrd_pkg::LEN_REG && req_index_i[15:12] == 4'h0;
  endsequence
  sequence s_four_bytes;
    (!setup_valid_i && out_valid_i) [*4];
  endsequence

  AST_ADDR_DEFER: assert property (
    dev_addr_o != $past(dev_addr_o) |-> $past(status_done_i && addr_pend_q))
    else $error("address changed outside a completed status stage");
  AST_ADDR_VALUE: assert property (
    setup_valid_i && req_code_i == ucrd_pkg::RQ_SET_ADDRESS && req_type_i == 8'h00 &&
    req_length_i == 16'h0000 ##1 (!setup_valid_i && status_done_i)
    |=> dev_addr_o == $past(req_value_i[6:0], 2))
    else $error("set address did not adopt the new address");
  AST_GET_CFG: assert property (
    s_get_cfg |=> in_valid_o && in_last_o && in_data_o == config_value_o)
    else $error("get configuration byte wrong");
  AST_DEV_STATUS: assert property (
    setup_valid_i && req_code_i == 8'h00 && req_type_i == ucrd_pkg::RT_DEV_IN &&
    req_index_i == 16'h0000 && req_length_i == ucrd_pkg::LEN_TWO
    |=> in_valid_o && in_data_o == {6'h00, $past(remote_wakeup_o), $past(selfp_sync_q[1])})
    else $error("device status byte wrong");
  AST_DESC_STALL: assert property (
    s_bad_desc |=> stall_o && !desc_req_o)
    else $error("unsupported descriptor not stalled");
  AST_DESC_REQ: assert property (
    setup_valid_i && req_code_i == ucrd_pkg::RQ_GET_DESC && req_type_i == 8'h80 &&
    req_value_i[15:8] == ucrd_pkg::DT_STRING |=> desc_req_o && !stall_o ##1 !desc_req_o)
    else $error("string descriptor not requested once");
  AST_SET_IFACE: assert property (
    setup_valid_i && req_code_i == ucrd_pkg::RQ_SET_IFACE && req_value_i != 16'h0000
    |=> stall_o)
    else $error("set interface with nonzero setting not stalled");
  AST_MAC_STALL: assert property (
    s_reg_wr and (normal_state_i && req_index_i[11:0] >= ucrd_pkg::MAC_CSR_BASE)
    |=> stall_o ##1 !csr_wr_o)
    else $error("MAC register write in normal state not stalled");
  AST_REG_WRITE: assert property (
    (s_reg_wr and !normal_state_i) ##1 s_four_bytes
    |=> csr_wr_o ##1 !csr_wr_o)
    else $error("register write not issued exactly once");
  AST_CLR_HALT: assert property (
    setup_valid_i && req_code_i == ucrd_pkg::RQ_CLR_FEATURE && req_type_i == 8'h02 &&
    req_value_i == 16'h0000 && req_length_i == 16'h0000 && ep_valid(req_index_i)
    |=> !ep_stall_o[$past(req_index_i[1:0])])
    else $error("endpoint halt not cleared");
  AST_UNSUPPORTED: assert property (
    setup_valid_i && (req_code_i == 8'h07 || req_code_i == 8'h0c) |=> stall_o)
    else $error("unsupported standard request not stalled");
endmodule

// File: test/ucrd_host_model.sv
// Purpose: Host side model that issues control transfers to the decoder.
// Assumes: Every line changes at the falling edge of sys_clk_i.
// Notes: Idle setup and data lines show inverted values, never a stale copy.
`timescale 1ns/1ps
module ucrd_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Setup and status stages
  output logic setup_valid_o,
  output logic [7:0] req_type_o,
  output logic [7:0] req_code_o,
  output logic [15:0] req_value_o,
  output logic [15:0] req_index_o,
  output logic [15:0] req_length_o,
  output logic status_done_o,
  // Data stages
  input wire logic [7:0] in_data_i,
  input wire logic in_valid_i,
  input wire logic in_last_i,
  output logic in_ready_o,
  output logic [7:0] out_data_o,
  output logic out_valid_o
);
  initial begin
    {setup_valid_o, status_done_o, in_ready_o, out_valid_o} = 4'h0;
    {req_type_o, req_code_o, out_data_o} = 24'h000000;
    {req_value_o, req_index_o, req_length_o} = 48'h000000000000;
  end

  task automatic setup(input logic [7:0] t, c, input logic [15:0] v, i, l);
    @(negedge sys_clk_i);
    setup_valid_o = 1'b1;
    {req_type_o, req_code_o, req_value_o, req_index_o, req_length_o} = {t, c, v, i, l};
    @(negedge sys_clk_i);
    setup_valid_o = 1'b0;
    {req_type_o, req_code_o, req_value_o, req_index_o, req_length_o} = ~{t, c, v, i, l};
  endtask

  // Called at a falling edge, so the pulse meets the very next rising edge.
  task automatic status();
    status_done_o = 1'b1;
    @(negedge sys_clk_i);
    status_done_o = 1'b0;
  endtask

  // Ready follows valid so a byte is taken at the edge after it is seen.
  task automatic read(input int n, output logic [15:0] d, output logic ok);
    int got;
    logic lok;
    got = 0;
    lok = 1'b1;
    d = 16'h0000;
    for (int k = 0; k < 20 && got < n; k++) begin
      @(negedge sys_clk_i);
      in_ready_o = in_valid_i;
      if (in_valid_i === 1'b1) begin
        d[got*8 +: 8] = in_data_i;
        if (in_last_i !== (got == n - 1)) lok = 1'b0;
        got++;
      end
    end
    @(negedge sys_clk_i);
    in_ready_o = 1'b0;
    ok = lok && got == n && in_valid_i === 1'b0;
  endtask

  // The first byte follows the setup at once, as a real data stage would.
  task automatic write(input logic [31:0] w);
    for (int k = 0; k < 4; k++) begin
      if (k > 0) @(negedge sys_clk_i);
      out_valid_o = 1'b1;
      out_data_o = w[k*8 +: 8];
    end
    @(negedge sys_clk_i);
    out_valid_o = 1'b0;
    out_data_o = ~out_data_o;
  endtask
endmodule

// File: test/test_usb_control_request_decoder.sv
// Purpose: Self-checking bench for the control request decoder.
// Assumes: The host model drives every request at the falling edge.
// Notes: Write and descriptor pulses are counted by monitors at the rising edge.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      $display("BAD %s expected %h seen %h", nm, exp, got); \
      miscompares++; \
    end \
  end
module test_usb_control_request_decoder;
  logic sys_clk_i, resetn_i, setup_valid_i, status_done_i, in_ready_i, out_valid_i;
  logic [7:0] req_type_i, req_code_i, out_data_i, in_data_o, desc_type_o, desc_index_o;
  logic [15:0] req_value_i, req_index_i, req_length_i, desc_length_o;
  logic in_valid_o, in_last_o, stall_o, desc_req_o, configured_o, remote_wakeup_o;
  logic self_powered_i, normal_state_i, test_mode_o, csr_wr_o;
  logic [6:0] dev_addr_o;
  logic [7:0] config_value_o, test_sel_o;
  logic [3:0] ep_stall_o;
  logic [11:0] csr_addr_o, wr_addr;
  logic [31:0] csr_wdata_o, wr_data;
  int miscompares = 0;
  int check_count = 0;
  int wr_count = 0;
  int desc_count = 0;

  ucrd_decoder dut (.sys_clk_i, .resetn_i, .setup_valid_i, .req_type_i, .req_code_i,
    .req_value_i, .req_index_i, .req_length_i, .status_done_i, .in_data_o, .in_valid_o,
    .in_last_o, .in_ready_i, .out_data_i, .out_valid_i, .stall_o, .desc_req_o, .desc_type_o,
    .desc_index_o, .desc_length_o, .self_powered_i, .normal_state_i, .dev_addr_o,
    .configured_o, .config_value_o, .remote_wakeup_o, .test_mode_o, .test_sel_o,
    .ep_stall_o, .csr_wr_o, .csr_addr_o, .csr_wdata_o);

  ucrd_host_model host (.sys_clk_i, .setup_valid_o(setup_valid_i), .req_type_o(req_type_i),
    .req_code_o(req_code_i), .req_value_o(req_value_i), .req_index_o(req_index_i),
    .req_length_o(req_length_i), .status_done_o(status_done_i), .in_data_i(in_data_o),
    .in_valid_i(in_valid_o), .in_last_i(in_last_o), .in_ready_o(in_ready_i),
    .out_data_o(out_data_i), .out_valid_o(out_valid_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    if (csr_wr_o === 1'b1) begin
      wr_count++;
      wr_addr = csr_addr_o;
      wr_data = csr_wdata_o;
    end
    if (desc_req_o === 1'b1) desc_count++;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmd(input string nm, input logic [7:0] t, c, input logic [15:0] v, i,
      input logic st);
    host.setup(t, c, v, i, 16'h0000);
    `CHK(nm, st, stall_o)
  endtask

  task automatic get(input string nm, input logic [7:0] t, c, input logic [15:0] i,
      input int n, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    host.setup(t, c, 16'h0000, i, n[15:0]);
    `CHK(nm, 1'b0, stall_o)
    host.read(n, d, ok);
    `CHK(nm, 1'b1, ok)
    `CHK(nm, exp, d)
    if (ok !== 1'b1) wrap_up();
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] w, input logic ns, ok);
    int c0;
    @(negedge sys_clk_i);
    normal_state_i = ns;
    c0 = wr_count;
    host.setup(8'h40, 8'ha0, 16'h0000, {4'h0, a}, 16'h0004);
    `CHK("wr_stall", !ok, stall_o)
    host.write(w);
    repeat (2) @(negedge sys_clk_i);
    `CHK("wr_count", c0 + int'(ok), wr_count)
    if (ok) `CHK("wr_addr", a, wr_addr)
    if (ok) `CHK("wr_data", w, wr_data)
  endtask

  task automatic t_basic();
    `CHK("rst_addr", 7'h00, dev_addr_o)
    `CHK("rst_ep", 4'h0, ep_stall_o)
    cmd("addr_set", 8'h00, 8'h05, 16'h002a, 16'h0000, 1'b0);
    `CHK("addr_early", 7'h00, dev_addr_o)
    host.status();
    @(negedge sys_clk_i);
    `CHK("addr_new", 7'h2a, dev_addr_o)
    cmd("cfg_set", 8'h00, 8'h09, 16'h0001, 16'h0000, 1'b0);
    `CHK("configured", 1'b1, configured_o)
    `CHK("cfg_value", 8'h01, config_value_o)
    get("cfg_get", 8'h80, 8'h08, 16'h0000, 1, 16'h0001);
    $display("test basic done");
  endtask

  task automatic t_wake();
    cmd("rwu_set", 8'h00, 8'h03, 16'h0001, 16'h0000, 1'b0);
    `CHK("rwu_on", 1'b1, remote_wakeup_o)
    get("dev_sts1", 8'h80, 8'h00, 16'h0000, 2, 16'h0003);
    cmd("rwu_clr", 8'h00, 8'h01, 16'h0001, 16'h0000, 1'b0);
    `CHK("rwu_off", 1'b0, remote_wakeup_o)
    get("dev_sts0", 8'h80, 8'h00, 16'h0000, 2, 16'h0001);
    $display("test wake done");
  endtask

  task automatic t_endpoints();
    logic [15:0] idx [3] = '{16'h0081, 16'h0002, 16'h0083};
    for (int k = 0; k < 3; k++) begin
      cmd("ep_halt", 8'h02, 8'h03, 16'h0000, idx[k], 1'b0);
      `CHK("ep_set", 4'h1 << (k + 1), ep_stall_o)
      get("ep_sts1", 8'h82, 8'h00, idx[k], 2, 16'h0001);
      cmd("ep_clr", 8'h02, 8'h01, 16'h0000, idx[k], 1'b0);
      `CHK("ep_off", 4'h0, ep_stall_o)
      get("ep_sts0", 8'h82, 8'h00, idx[k], 2, 16'h0000);
    end
    cmd("ep_bad", 8'h02, 8'h03, 16'h0000, 16'h0004, 1'b1);
    `CHK("ep_bad_st", 4'h0, ep_stall_o)
    $display("test endpoints done");
  endtask

  task automatic t_desc();
    logic [7:0] ty [7] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h04, 8'h05};
    int c0;
    for (int k = 0; k < 7; k++) begin
      c0 = desc_count;
      host.setup(8'h80, 8'h06, {ty[k], k[7:0]}, (k == 2) ? 16'h0409 : 16'h0000, 16'h0012);
      `CHK("desc_stall", k > 4, stall_o)
      @(negedge sys_clk_i);
      `CHK("desc_req", c0 + int'(k < 5), desc_count)
      if (k < 5) `CHK("desc_type", ty[k], desc_type_o)
      if (k < 5) `CHK("desc_idx", k[7:0], desc_index_o)
      if (k < 5) `CHK("desc_len", 16'h0012, desc_length_o)
    end
    $display("test descriptors done");
  endtask

  task automatic t_misc();
    get("if_get", 8'h81, 8'h0a, 16'h0000, 1, 16'h0000);
    cmd("if_ok", 8'h01, 8'h0b, 16'h0000, 16'h0000, 1'b0);
    cmd("if_alt", 8'h01, 8'h0b, 16'h0001, 16'h0000, 1'b1);
    cmd("if_num", 8'h01, 8'h0b, 16'h0000, 16'h0001, 1'b1);
    cmd("set_desc", 8'h00, 8'h07, 16'h0100, 16'h0000, 1'b1);
    cmd("synch", 8'h82, 8'h0c, 16'h0000, 16'h0081, 1'b1);
    cmd("bad_code", 8'h00, 8'h55, 16'h0000, 16'h0000, 1'b1);
    wr(12'h123, 32'h44332211, 1'b0, 1'b1);
    wr(12'h120, 32'h0badf00d, 1'b1, 1'b0);
    wr(12'h010, 32'ha5c30f96, 1'b1, 1'b1);
    cmd("test_mode", 8'h00, 8'h03, 16'h0002, 16'h0400, 1'b0);
    `CHK("test_on", 1'b1, test_mode_o)
    `CHK("test_sel", 8'h04, test_sel_o)
    $display("test misc done");
  endtask

  initial begin
    resetn_i = 1'b0;
    self_powered_i = 1'b1;
    normal_state_i = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    t_basic();
    t_wake();
    t_endpoints();
    t_desc();
    t_misc();
    wrap_up();
  end
endmodule
